// ### src/pom_port_pin_override_mux.sv
// one I/O port with alternate-function overrides and an AXI4-Lite slave
`timescale 1ns/10ps
// Overview of operation
// - deep sleep clamps digital input to ground
// - enabled external interrupt pins escape the clamp
// - high edge-mode pin with interrupt disabled flags on sleep resume
// - pull-up override enable selects override value
// - plain pull-up needs dir/latch/disable = 010
// - direction override value drives output enable
// - otherwise direction bit drives output enable
// - value override replaces latch on driven pin
// - otherwise the output latch drives the pin
// - toggle override inverts the output latch
// - input override value sets input enable
// - otherwise sleep state gates input enable
// - raw input taken before the read synchronizer
// - analog path passes pad without gating
// - strobes per port, clamp/disable shared
// - global pull-up disable kills plain pull-ups
// - direction one is output, zero input
module pom_port_pin_override_mux import pom_pkg::*; #(
	parameter int PINS = POM_PINS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire pom_axi_req_t axiReq,
	output pom_axi_rsp_t axiRsp,
	input wire logic [PINS-1:0] padIn,
	output logic [PINS-1:0] padOut,
	output logic [PINS-1:0] padOe,
	output logic [PINS-1:0] pullupEn,
	input wire logic sleepClamp,
	input wire logic [PINS-1:0] extIntEnable,
	input wire logic [PINS-1:0] extIntEdgeMode,
	input wire pom_ovr_t [PINS-1:0] pinOvr,
	output logic [PINS-1:0] rawPinInput,
	output logic [PINS-1:0] analogPadPath,
	output logic [PINS-1:0] extIntFlagSet
);
	typedef struct packed {
		logic [PINS-1:0] dir;
		logic [PINS-1:0] latch;
		logic [PINS-1:0] syncA;
		logic [PINS-1:0] syncB;
		logic [PINS-1:0] wake;
		logic [PINS-1:0] padOut;
		logic [PINS-1:0] padOe;
		logic [PINS-1:0] pullupEn;
		logic [PINS-1:0] rawIn;
		logic [PINS-1:0] analog;
		logic [PINS-1:0] wakePulse;
		logic global_pullup_disable;
		logic sleepPrev;
		logic awHeld;
		logic awHigh;
		logic [7:0] awOfs;
		logic wHeld;
		logic wLane0;
		logic [PINS-1:0] wData;
		logic awRdy;
		logic wRdy;
		logic arRdy;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [PINS-1:0] rdata;
		logic [1:0] rresp;
	} pom_state_t;

	pom_state_t cur_ff;
	pom_state_t nxt_state;
	pom_pin_ctl_t [PINS-1:0] pinCtl;

	// the cells read only registered port bits, so pad outputs are one
	// cycle behind a register write but never glitch on bus decode
	for (genvar i = 0; i < PINS; i++) begin : g_pin
		pom_pin_cell u_cell (
			.ovr(pinOvr[i]),
			.pinDirectionBit(cur_ff.dir[i]),
			.pinOutputLatchBit(cur_ff.latch[i]),
			.globalPullupDisable(cur_ff.global_pullup_disable),
			.sleepClamp(sleepClamp),
			.extIntEnable(extIntEnable[i]),
			.ctl(pinCtl[i])
		);
	end

	always_comb begin
		logic [PINS-1:0] digIn;
		logic [PINS-1:0] wakeClr;
		logic [PINS-1:0] wakeSet;
		logic wrStrobeDirection;
		logic wrStrobeLatch;
		logic wrStrobeToggle;
		logic rdStrobeDirection;
		logic rdStrobeLatch;
		logic rdStrobePin;
		logic wrStrobeCtrl;
		logic wrStrobeWake;
		logic rdStrobeCtrl;
		logic rdStrobeWake;
		logic hit;
		digIn = '0;
		wakeClr = '0;
		wakeSet = '0;
		wrStrobeDirection = 1'b0;
		wrStrobeLatch = 1'b0;
		wrStrobeToggle = 1'b0;
		rdStrobeDirection = 1'b0;
		rdStrobeLatch = 1'b0;
		rdStrobePin = 1'b0;
		wrStrobeCtrl = 1'b0;
		wrStrobeWake = 1'b0;
		rdStrobeCtrl = 1'b0;
		rdStrobeWake = 1'b0;
		hit = 1'b0;
		nxt_state = cur_ff;

		// write channel: address and data taken in either order
		if (axiReq.awvalid && cur_ff.awRdy) begin
			nxt_state.awHeld = 1'b1;
			nxt_state.awOfs = axiReq.awaddr[7:0];
			nxt_state.awHigh = |axiReq.awaddr[31:8];
		end
		if (axiReq.wvalid && cur_ff.wRdy) begin
			nxt_state.wHeld = 1'b1;
			nxt_state.wData = axiReq.wdata[PINS-1:0];
			nxt_state.wLane0 = axiReq.wstrb[0];
		end
		if (cur_ff.bvalid && axiReq.bready)
			nxt_state.bvalid = 1'b0;
		if (nxt_state.awHeld && nxt_state.wHeld && !cur_ff.bvalid) begin
			// one strobe per register serves every pin of the port
			// a cleared lane 0 still answers okay but changes nothing
			if (!nxt_state.awHigh) begin
				case (nxt_state.awOfs)
					POM_DIR_OFS: begin
						hit = 1'b1;
						wrStrobeDirection = nxt_state.wLane0;
					end
					POM_LATCH_OFS: begin
						hit = 1'b1;
						wrStrobeLatch = nxt_state.wLane0;
					end
					POM_PIN_OFS: begin
						hit = 1'b1;
						wrStrobeToggle = nxt_state.wLane0;
					end
					POM_CTRL_OFS: begin
						hit = 1'b1;
						wrStrobeCtrl = nxt_state.wLane0;
					end
					POM_WAKE_OFS: begin
						hit = 1'b1;
						wrStrobeWake = nxt_state.wLane0;
					end
					default: hit = 1'b0;
				endcase
			end
			nxt_state.bresp = hit ? POM_RESP_OKAY : POM_RESP_SLVERR;
			nxt_state.bvalid = 1'b1;
			nxt_state.awHeld = 1'b0;
			nxt_state.wHeld = 1'b0;
		end
		if (wrStrobeCtrl)
			nxt_state.global_pullup_disable = nxt_state.wData[POM_PUD_BIT];
		if (wrStrobeWake)
			wakeClr = nxt_state.wData;
		if (wrStrobeDirection)
			nxt_state.dir = nxt_state.wData;
		if (wrStrobeLatch)
			nxt_state.latch = nxt_state.wData;
		if (wrStrobeToggle)
			nxt_state.latch = nxt_state.latch ^ nxt_state.wData;
		for (int i = 0; i < PINS; i++) begin
			if (pinOvr[i].latchToggleOverrideEn)
				nxt_state.latch[i] = ~nxt_state.latch[i];
		end
		nxt_state.awRdy = !nxt_state.awHeld && !nxt_state.bvalid;
		nxt_state.wRdy = !nxt_state.wHeld && !nxt_state.bvalid;

		// read channel
		if (cur_ff.rvalid && axiReq.rready)
			nxt_state.rvalid = 1'b0;
		if (axiReq.arvalid && cur_ff.arRdy) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp = POM_RESP_OKAY;
			nxt_state.rdata = '0;
			if (|axiReq.araddr[31:8]) begin
				nxt_state.rresp = POM_RESP_SLVERR;
			end else begin
				case (axiReq.araddr[7:0])
					POM_DIR_OFS: rdStrobeDirection = 1'b1;
					POM_LATCH_OFS: rdStrobeLatch = 1'b1;
					POM_PIN_OFS: rdStrobePin = 1'b1;
					POM_CTRL_OFS: rdStrobeCtrl = 1'b1;
					POM_WAKE_OFS: rdStrobeWake = 1'b1;
					default: nxt_state.rresp = POM_RESP_SLVERR;
				endcase
			end
		end
		// at most one read strobe is high, so the order below is free
		if (rdStrobeDirection)
			nxt_state.rdata = cur_ff.dir;
		if (rdStrobeLatch)
			nxt_state.rdata = cur_ff.latch;
		if (rdStrobePin)
			nxt_state.rdata = cur_ff.syncB;
		if (rdStrobeCtrl)
			nxt_state.rdata[POM_PUD_BIT] = cur_ff.global_pullup_disable;
		if (rdStrobeWake)
			nxt_state.rdata = cur_ff.wake;
		nxt_state.arRdy = !nxt_state.rvalid;

		// pad side
		for (int i = 0; i < PINS; i++)
			digIn[i] = padIn[i] & pinCtl[i].inputEn;
		nxt_state.syncA = digIn;
		nxt_state.syncB = cur_ff.syncA;
		nxt_state.rawIn = digIn;
		nxt_state.analog = padIn;
		for (int i = 0; i < PINS; i++) begin
			nxt_state.padOe[i] = pinCtl[i].driveEn;
			nxt_state.padOut[i] = pinCtl[i].driveVal;
			nxt_state.pullupEn[i] = pinCtl[i].pullupOn;
		end

		// releasing the clamp makes a high pin look like a rising edge
		nxt_state.sleepPrev = sleepClamp;
		if (cur_ff.sleepPrev && !sleepClamp)
			wakeSet = padIn & extIntEdgeMode & ~extIntEnable;
		nxt_state.wakePulse = wakeSet;
		nxt_state.wake = (cur_ff.wake & ~wakeClr) | wakeSet;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_ff <= '0;
			cur_ff.dir <= POM_DIR_RST[PINS-1:0];
			cur_ff.latch <= POM_LATCH_RST[PINS-1:0];
			cur_ff.global_pullup_disable <= POM_PUD_RST;
		end else if (clkEn) begin
			cur_ff <= nxt_state;
		end
	end

	always_comb begin
		axiRsp.awready = cur_ff.awRdy;
		axiRsp.wready = cur_ff.wRdy;
		axiRsp.bvalid = cur_ff.bvalid;
		axiRsp.bresp = cur_ff.bresp;
		axiRsp.arready = cur_ff.arRdy;
		axiRsp.rvalid = cur_ff.rvalid;
		axiRsp.rdata = {{(32-PINS){1'b0}}, cur_ff.rdata};
		axiRsp.rresp = cur_ff.rresp;
	end
	assign padOut = cur_ff.padOut;
	assign padOe = cur_ff.padOe;
	assign pullupEn = cur_ff.pullupEn;
	assign rawPinInput = cur_ff.rawIn;
	assign analogPadPath = cur_ff.analog;
	assign extIntFlagSet = cur_ff.wakePulse;
endmodule : pom_port_pin_override_mux

// ### src/pom_pkg.sv
// shared constants and carrier types for the port pin override block
package pom_pkg;
	localparam int POM_PINS = 8;
	localparam int POM_REG_W = 8;
	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] POM_DIR_OFS = 8'h00;
	localparam logic [7:0] POM_LATCH_OFS = 8'h04;
	localparam logic [7:0] POM_PIN_OFS = 8'h08;
	localparam logic [7:0] POM_CTRL_OFS = 8'h0c;
	localparam logic [7:0] POM_WAKE_OFS = 8'h10;
	// control register field
	localparam int POM_PUD_BIT = 4;
	// values after reset
	localparam logic [7:0] POM_DIR_RST = 8'h00;
	localparam logic [7:0] POM_LATCH_RST = 8'h00;
	localparam logic POM_PUD_RST = 1'b0;
	// answer codes
	localparam logic [1:0] POM_RESP_OKAY = 2'h0;
	localparam logic [1:0] POM_RESP_SLVERR = 2'h2;

	// per-pin override set produced by a peripheral
	typedef struct packed {
		logic pullupOverrideEn;
		logic pullupOverrideVal;
		logic dirOverrideEn;
		logic dirOverrideVal;
		logic outvalOverrideEn;
		logic outvalOverrideVal;
		logic latchToggleOverrideEn;
		logic inenOverrideEn;
		logic inenOverrideVal;
	} pom_ovr_t;

	// resolved pad controls of one pin
	typedef struct packed {
		logic pullupOn;
		logic driveEn;
		logic driveVal;
		logic inputEn;
	} pom_pin_ctl_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} pom_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pom_axi_rsp_t;
endpackage : pom_pkg

// ### src/pom_pin_cell.sv
// combinational override resolution for one pin
`timescale 1ns/10ps
module pom_pin_cell import pom_pkg::*; (
	input wire pom_ovr_t ovr,
	input wire logic pinDirectionBit,
	input wire logic pinOutputLatchBit,
	input wire logic globalPullupDisable,
	input wire logic sleepClamp,
	input wire logic extIntEnable,
	output pom_pin_ctl_t ctl
);
	logic plainPullup;
	logic sleepGate;

	// pull-up only for {dir, latch, pud} = 3'b010
	assign plainPullup = ~pinDirectionBit & pinOutputLatchBit
		& ~globalPullupDisable;
	// an enabled external interrupt keeps its input alive in sleep
	assign sleepGate = sleepClamp & ~extIntEnable;

	always_comb begin
		ctl.pullupOn = ovr.pullupOverrideEn ? ovr.pullupOverrideVal
			: plainPullup;
		ctl.driveEn = ovr.dirOverrideEn ? ovr.dirOverrideVal
			: pinDirectionBit;
		ctl.driveVal = ovr.outvalOverrideEn ? ovr.outvalOverrideVal
			: pinOutputLatchBit;
		ctl.inputEn = ovr.inenOverrideEn ? ovr.inenOverrideVal
			: ~sleepGate;
	end
endmodule : pom_pin_cell

// ### bench/pom_periph_model.sv
// peripheral stand-in that owns the pin 0 override set
`timescale 1ns/10ps
module pom_periph_model import pom_pkg::*; #(
	parameter int PINS = POM_PINS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire pom_ovr_t modeReq,
	input wire logic [PINS-1:0] rawPinInput,
	output pom_ovr_t [PINS-1:0] pinOvr,
	output logic [PINS-1:0] syncIn_ff
);
	logic [PINS-1:0] meta_ff;
	always_comb begin
		pinOvr = '0;
		pinOvr[0] = modeReq;
	end
	// raw input is unsynchronized, so two flops before any use
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_ff <= '0;
			syncIn_ff <= '0;
		end else begin
			meta_ff <= rawPinInput;
			syncIn_ff <= meta_ff;
		end
	end
endmodule : pom_periph_model

// ### bench/pom_port_pin_override_mux_sva.sv
// pin 0 override and sleep clamp checks
`timescale 1ns/10ps
module pom_port_pin_override_mux_sva import pom_pkg::*; #(
	parameter int PINS = POM_PINS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [PINS-1:0] padIn,
	input wire logic [PINS-1:0] padOut,
	input wire logic [PINS-1:0] padOe,
	input wire logic [PINS-1:0] pullupEn,
	input wire logic sleepClamp,
	input wire logic [PINS-1:0] extIntEnable,
	input wire logic [PINS-1:0] extIntEdgeMode,
	input wire pom_ovr_t [PINS-1:0] pinOvr,
	input wire logic [PINS-1:0] rawPinInput,
	input wire logic [PINS-1:0] analogPadPath,
	input wire logic [PINS-1:0] extIntFlagSet
);
	pom_ovr_t o;
	logic live_ff;
	assign o = pinOvr[0];
	// previous edge was a working edge out of reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) live_ff <= 1'b0;
		else live_ff <= clkEn;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_pullup_ovr: assert property (
		live_ff && $past(o.pullupOverrideEn) |->
		pullupEn[0] == $past(o.pullupOverrideVal)) else $error("pullup ovr");
	a_dir_ovr: assert property (
		live_ff && $past(o.dirOverrideEn) |->
		padOe[0] == $past(o.dirOverrideVal)) else $error("dir ovr");
	a_val_ovr: assert property (
		live_ff && $past(o.outvalOverrideEn) && padOe[0] |->
		padOut[0] == $past(o.outvalOverrideVal)) else $error("value ovr");
	a_inen_ovr: assert property (
		live_ff && $past(o.inenOverrideEn) |->
		rawPinInput[0] == $past(padIn[0] & o.inenOverrideVal))
		else $error("input ovr");
	a_sleep_clamp: assert property (
		live_ff && $past(sleepClamp && !extIntEnable[0] &&
		!o.inenOverrideEn) |-> !rawPinInput[0]) else $error("clamp");
	a_clamp_escape: assert property (
		live_ff && $past(!o.inenOverrideEn && (!sleepClamp ||
		extIntEnable[0])) |-> rawPinInput[0] == $past(padIn[0]))
		else $error("raw input");
	a_analog_path: assert property (
		live_ff |-> analogPadPath == $past(padIn)) else $error("analog");
	a_resume_flag: assert property (
		live_ff && $fell(sleepClamp) && padIn[0] && extIntEdgeMode[0] &&
		!extIntEnable[0] |-> ##[1:2] extIntFlagSet[0]) else $error("resume");
	c_sleep: cover property (live_ff && sleepClamp);
	c_flag: cover property (extIntFlagSet[0]);
	c_dir: cover property (live_ff && o.dirOverrideEn);
endmodule : pom_port_pin_override_mux_sva

bind pom_port_pin_override_mux pom_port_pin_override_mux_sva #(
	.PINS(PINS)
) u_pom_port_pin_override_mux_sva (
	.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
	.padIn(padIn), .padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
	.sleepClamp(sleepClamp), .extIntEnable(extIntEnable),
	.extIntEdgeMode(extIntEdgeMode), .pinOvr(pinOvr),
	.rawPinInput(rawPinInput), .analogPadPath(analogPadPath),
	.extIntFlagSet(extIntFlagSet)
);

// ### bench/tb_pom_port_pin_override_mux.sv
// self-checking bench for the port pin override block
`timescale 1ns/10ps
module tb_pom_port_pin_override_mux import pom_pkg::*; ;
	logic core_clk, sys_rst, sleepClamp, seen, clkEn;
	pom_axi_req_t req;
	pom_axi_rsp_t rsp;
	pom_ovr_t mode;
	pom_ovr_t [7:0] ovr;
	logic [7:0] padIn, padOut, padOe, pullupEn, eiEn, eiMode, raw, ana, flag;
	logic [7:0] syncIn;
	logic [31:0] rd;
	logic [1:0] resp;
	int miscompares, n_tests;
	int cyc = 0;
	pom_port_pin_override_mux u_pom_port_pin_override_mux (
		.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.axiReq(req), .axiRsp(rsp), .padIn(padIn), .padOut(padOut),
		.padOe(padOe), .pullupEn(pullupEn), .sleepClamp(sleepClamp),
		.extIntEnable(eiEn), .extIntEdgeMode(eiMode), .pinOvr(ovr),
		.rawPinInput(raw), .analogPadPath(ana), .extIntFlagSet(flag)
	);
	pom_periph_model u_pom_periph_model (
		.core_clk(core_clk), .sys_rst(sys_rst), .modeReq(mode),
		.rawPinInput(raw), .pinOvr(ovr), .syncIn_ff(syncIn)
	);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic settle();
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
	endtask : settle
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'b0;
		@(posedge core_clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!b) begin
			@(negedge core_clk);
			aw = req.awvalid && rsp.awready;
			w = req.wvalid && rsp.wready;
			b = req.bready && rsp.bvalid;
			if (b) resp = rsp.bresp;
			@(posedge core_clk);
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
			if (b) req.bready <= 1'b0;
		end
	endtask : wr
	task automatic rdr(input logic [31:0] a);
		logic ar, r;
		r = 1'b0;
		@(posedge core_clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		while (!r) begin
			@(negedge core_clk);
			ar = req.arvalid && rsp.arready;
			r = req.rready && rsp.rvalid;
			rd = rsp.rdata;
			resp = rsp.rresp;
			@(posedge core_clk);
			if (ar) req.arvalid <= 1'b0;
			if (r) req.rready <= 1'b0;
		end
	endtask : rdr
	task automatic t_drive();
		rdr(32'h0000_0100);
		chk(resp, POM_RESP_SLVERR);
		wr(32'h0000_0014, 32'h0000_00ff);
		chk(resp, POM_RESP_SLVERR);
		wr(POM_DIR_OFS, 32'h0000_000f);
		wr(POM_LATCH_OFS, 32'h0000_0005);
		chk(resp, POM_RESP_OKAY);
		settle();
		chk(padOe, 8'h0f);
		chk(padOut & padOe, 8'h05);
		@(posedge core_clk);
		mode <= '{latchToggleOverrideEn: 1'b1, default: 1'b0};
		@(posedge core_clk);
		mode <= '{dirOverrideEn: 1'b1, default: 1'b0};
		rdr(POM_LATCH_OFS);
		chk(rd, 32'h0000_0004);
		settle();
		chk(padOe, 8'h0e);
		@(posedge core_clk);
		mode <= '{dirOverrideEn: 1, dirOverrideVal: 1, outvalOverrideEn: 1,
			outvalOverrideVal: 1, default: 0};
		settle();
		chk(padOut & padOe, 8'h05);
		wr(POM_PIN_OFS, 32'h0000_0003);
		rdr(POM_LATCH_OFS);
		chk(rd, 32'h0000_0007);
	endtask : t_drive
	task automatic t_pullup();
		@(posedge core_clk);
		mode <= '0;
		wr(POM_DIR_OFS, 32'h0000_0000);
		wr(POM_LATCH_OFS, 32'h0000_00ff);
		settle();
		chk(pullupEn, 8'hff);
		wr(POM_CTRL_OFS, 32'(1) << POM_PUD_BIT);
		settle();
		chk(pullupEn, 8'h00);
		@(posedge core_clk);
		mode <= '{pullupOverrideEn: 1, pullupOverrideVal: 1, default: 0};
		settle();
		chk(pullupEn, 8'h01);
	endtask : t_pullup
	// a low clock enable must hold the pads while the overrides move
	task automatic t_freeze();
		@(posedge core_clk);
		clkEn <= 1'b0;
		mode <= '{dirOverrideEn: 1, dirOverrideVal: 1, default: 0};
		settle();
		chk(padOe, 8'h00);
		chk(pullupEn, 8'h01);
		@(posedge core_clk);
		clkEn <= 1'b1;
		settle();
		chk(padOe, 8'h01);
		chk(pullupEn, 8'h00);
	endtask : t_freeze
	task automatic t_sleep();
		@(posedge core_clk);
		mode <= '0;
		padIn <= 8'hff;
		eiEn <= 8'h02;
		sleepClamp <= 1'b1;
		settle();
		chk(raw, 8'h02);
		chk(ana, 8'hff);
		@(posedge core_clk);
		mode <= '{inenOverrideEn: 1, inenOverrideVal: 1, default: 0};
		settle();
		chk(raw, 8'h03);
		@(posedge core_clk);
		mode <= '{inenOverrideEn: 1, default: 0};
		sleepClamp <= 1'b0;
		settle();
		settle();
		chk(raw, 8'hfe);
		chk(syncIn, 8'hfe);
		rdr(POM_PIN_OFS);
		chk(rd, 32'h0000_00fe);
	endtask : t_sleep
	task automatic t_resume();
		@(posedge core_clk);
		mode <= '0;
		eiEn <= 8'h00;
		eiMode <= 8'h01;
		sleepClamp <= 1'b1;
		settle();
		@(posedge core_clk);
		sleepClamp <= 1'b0;
		seen = 1'b0;
		repeat (4) begin
			@(negedge core_clk);
			seen = seen | flag[0];
		end
		chk(seen, 1'b1);
		rdr(POM_WAKE_OFS);
		chk(rd, 32'h0000_0001);
		wr(POM_WAKE_OFS, 32'h0000_0001);
		rdr(POM_WAKE_OFS);
		chk(rd, 32'h0000_0000);
	endtask : t_resume
	initial begin
		sys_rst = 1'b1;
		req = '0;
		req.wstrb = 4'hf;
		mode = '0;
		padIn = '0;
		eiEn = '0;
		eiMode = '0;
		sleepClamp = 1'b0;
		clkEn = 1'b1;
		miscompares = 0;
		n_tests = 0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_drive();
		t_pullup();
		t_freeze();
		t_sleep();
		t_resume();
		test_done();
	end
endmodule : tb_pom_port_pin_override_mux
